//--- rtl/acs_pkg.sv
// package for the converter control sequencer: word layout, modes, frame counts
package acs_pkg;
   localparam int FRAME_BITS = 16;
   localparam int CFG_BITS = 12;
   localparam int CFG_W = 11;
   localparam int RES_BITS = 12;
   localparam int BIT_WRITE = 11;
   localparam int BIT_SEQ_HI = 10;
   localparam int BIT_ADDR_HI = 7;
   localparam int BIT_ADDR_LO = 6;
   localparam int BIT_PM_HI = 5;
   localparam int BIT_PM_LO = 4;
   localparam int BIT_SEQ_LO = 3;
   localparam int BIT_RANGE = 1;
   localparam int BIT_CODING = 0;
   localparam int MUX_EDGE = 14;
   localparam logic [10:0] CFG_RESET = 11'h7_F3;
   localparam int CLK_MHZ = 250;
   localparam int WAKE_NS = 1000;
   localparam int WAKE_CYC = (WAKE_NS * CLK_MHZ + 999) / 1000;
   typedef enum logic [1:0] {
      ACS_PM_INVALID = 2'b00,
      ACS_PM_AUTO = 2'b01,
      ACS_PM_FULL_OFF = 2'b10,
      ACS_PM_NORMAL = 2'b11
   } acs_pm_t;
   typedef enum logic [1:0] {
      ACS_SEQ_OFF0 = 2'b00,
      ACS_SEQ_OFF1 = 2'b01,
      ACS_SEQ_KEEP = 2'b10,
      ACS_SEQ_CONT = 2'b11
   } acs_seq_t;
endpackage

//--- rtl/acs_sync.sv
// two flip-flop level synchroniser
`timescale 1ns/1ps
module acs_sync #(
   parameter int W = 1
) (
   input wire logic clk_in,
   input wire logic [W-1:0] d_in,
   output logic [W-1:0] q_out
);
   logic [W-1:0] meta_q;
   always_ff @(posedge clk_in)
   begin
      meta_q <= d_in;
      q_out <= meta_q;
   end
endmodule // acs_sync

//--- rtl/acs_ctrl.sv
// serial link frame engine and configuration/sequencer control
// How it works
// - write bit high loads the other 11 bits, else config unchanged
// - sequencer mode is bits 10 and 3 together
// - address bits take effect on the 14th falling edge of the frame that writes them
// - channel address of the result goes out before the result bits
// - mux moves to the next channel on the 14th falling serial edge
// - bits 5 and 4 form the power mode
// - bit 1 picks range: 0 twice reference, 1 reference
// - bit 0 picks coding: 0 twos complement, 1 straight binary
// - power mode 11 keeps the core fully powered always
// - power mode 10 shuts all down, keeps config, until rewritten
// - power mode 01 shuts down after each conversion that updates config
// - sequencer high bit 0 uses the address of the current write
// - mode 10 keeps a running sequence while other bits change
// - mode 11 converts channels 0 up to the final address continuously
// - word shifted msb first, 16 clocks, the 11 bits after the write bit reach config
// - output word is two zeros, two address bits, then padded result
`timescale 1ns/1ps
module acs_ctrl
   import acs_pkg::*;
#(
   parameter int RES_W = acs_pkg::RES_BITS
) (
   input wire logic sys_clk_in,
   input wire logic nrst_in,
   input wire logic sclk_in,
   input wire logic cs_n_in,
   input wire logic din_in,
   output logic dout_out,
   output logic dout_oe_out,
   input wire logic [RES_W-1:0] result_in,
   output logic [1:0] mux_channel_out,
   output logic conv_start_out,
   output logic core_power_on_out,
   output logic range_ref_only_out,
   output logic coding_binary_out,
   output logic [1:0] power_mode_out,
   output logic [1:0] sequence_mode_out,
   output logic wake_ready_out
);
   import acs_pkg::*;

   // link domain: everything here runs on falling serial clock edges
   logic [3:0] bit_cnt_q;
   logic [CFG_BITS-2:0] shift_q;
   logic [FRAME_BITS-1:0] out_sr_q;
   logic [CFG_W-1:0] cfg_q;
   logic cfg_upd_q;
   logic [1:0] chan_q;
   logic seq_run_q;
   logic frame_done_q;
   logic [RES_BITS-1:0] res_frame;
   logic cs_q;
   logic [CFG_W-1:0] next_cfg;
   logic write_en;
   logic [1:0] seq_mode;
   logic [1:0] next_chan;
   logic [1:0] final_chan;
   logic seq_active;

   function automatic logic [1:0] seq_of(input logic [CFG_W-1:0] c);
      seq_of = {c[BIT_SEQ_HI], c[BIT_SEQ_LO]};
   endfunction

   function automatic logic [1:0] addr_of(input logic [CFG_W-1:0] c);
      addr_of = {c[BIT_ADDR_HI], c[BIT_ADDR_LO]};
   endfunction

   // word completes on the 12th edge: 11 shifted bits plus the live din
   assign write_en = shift_q[CFG_BITS-2];
   assign next_cfg = {shift_q[CFG_BITS-3:0], din_in};
   assign seq_mode = seq_of(cfg_q);
   assign final_chan = addr_of(cfg_q);
   assign seq_active = seq_mode[1] && seq_run_q;
   // sequence wraps to channel 0 after the final channel
   assign next_chan = (chan_q >= final_chan) ? 2'b00 : 2'(chan_q + 2'b01);

   always_ff @(negedge sclk_in)
   begin
      cs_q <= cs_n_in;
      if (cs_n_in)
      begin
         bit_cnt_q <= 4'h0;
      end
      else
      begin
         bit_cnt_q <= 4'(bit_cnt_q + 4'h1);
         if (bit_cnt_q < 4'(CFG_BITS - 1))
         begin
            shift_q <= {shift_q[CFG_BITS-3:0], din_in};
         end
      end
   end

   // config register has no reset path from the fast domain; it starts from
   // the first frame, so sys logic ignores it until a frame has been seen
   always_ff @(negedge sclk_in)
   begin
      if (!cs_n_in && bit_cnt_q == 4'(CFG_BITS - 1))
      begin
         cfg_upd_q <= write_en;
         if (write_en)
         begin
            cfg_q <= next_cfg;
         end
      end
      else if (cs_q && !cs_n_in)
      begin
         cfg_upd_q <= 1'b0;
      end
   end

   // channel selection happens on the 14th falling edge of the frame
   always_ff @(negedge sclk_in)
   begin
      if (!cs_n_in && bit_cnt_q == 4'(MUX_EDGE - 1))
      begin
         if (cfg_upd_q && !seq_mode[1])
         begin
            chan_q <= final_chan;
            seq_run_q <= 1'b0;
         end
         else if (cfg_upd_q && seq_mode == 2'(ACS_SEQ_CONT) && !seq_run_q)
         begin
            chan_q <= 2'b00;
            seq_run_q <= 1'b1;
         end
         else if (seq_active)
         begin
            chan_q <= next_chan;
         end
      end
   end

   // frame-done level from the 14th edge to the next idle fall; a plain level
   // settles by itself, where a toggle would need a reset this domain lacks
   always_ff @(negedge sclk_in)
   begin
      frame_done_q <= !cs_n_in && (bit_cnt_q >= 4'(MUX_EDGE - 1));
   end

   // output word: two zeros, address, result msb first, zero padded
   assign res_frame = RES_BITS'(result_in) << (RES_BITS - RES_W);
   always_ff @(negedge sclk_in)
   begin
      if (cs_n_in)
      begin
         out_sr_q <= {2'b00, chan_q, res_frame};
      end
      else
      begin
         out_sr_q <= {out_sr_q[FRAME_BITS-2:0], 1'b0};
      end
   end

   assign dout_out = out_sr_q[FRAME_BITS-1];
   assign dout_oe_out = ~cs_n_in;
   assign mux_channel_out = chan_q;

   // system domain: decoded configuration and power state
   logic [CFG_W-1:0] cfg_s;
   logic done_s;
   logic done_d_q;
   logic seen_q;
   logic [CFG_W-1:0] cfg_live_q;
   logic upd_s;
   logic shut_q;
   logic [15:0] wake_cnt_q;
   logic frame_evt;
   logic [1:0] pm;

   acs_sync #(
      .W(CFG_W + 2)
   ) u_sync (
      .clk_in(sys_clk_in),
      .d_in({frame_done_q, cfg_upd_q, cfg_q}),
      .q_out({done_s, upd_s, cfg_s})
   );

   // config settles two link edges before the done level rises, so it is safe
   // to take on the rise; no event counts until the level was seen low
   assign frame_evt = seen_q & done_s & ~done_d_q;
   assign pm = {cfg_live_q[BIT_PM_HI], cfg_live_q[BIT_PM_LO]};

   always_ff @(posedge sys_clk_in)
   begin
      if (!nrst_in)
      begin
         done_d_q <= 1'b0;
         seen_q <= 1'b0;
         cfg_live_q <= CFG_RESET;
         shut_q <= 1'b0;
         wake_cnt_q <= 16'h0000;
      end
      else
      begin
         done_d_q <= done_s;
         if (!done_s)
         begin
            seen_q <= 1'b1;
         end
         if (frame_evt && upd_s)
         begin
            cfg_live_q <= cfg_s;
         end
         if (pm == 2'(ACS_PM_FULL_OFF))
         begin
            shut_q <= 1'b1;
         end
         else if (pm == 2'(ACS_PM_AUTO) && frame_evt && upd_s)
         begin
            shut_q <= 1'b1;
         end
         else if (frame_evt || pm == 2'(ACS_PM_NORMAL))
         begin
            shut_q <= 1'b0;
         end
         // wake counter gives the host's settling interval a visible flag
         if (shut_q)
         begin
            wake_cnt_q <= 16'(WAKE_CYC);
         end
         else if (wake_cnt_q != 16'h0000)
         begin
            wake_cnt_q <= 16'(wake_cnt_q - 16'h0001);
         end
      end
   end

   // power mode 00 is illegal from the host; never shuts down, but power returns only at the next frame
   assign core_power_on_out = ~shut_q;
   assign power_mode_out = pm;
   assign sequence_mode_out = seq_of(cfg_live_q);
   assign range_ref_only_out = cfg_live_q[BIT_RANGE];
   assign coding_binary_out = cfg_live_q[BIT_CODING];
   assign conv_start_out = frame_evt;
   assign wake_ready_out = (wake_cnt_q == 16'h0000) & ~shut_q;
endmodule // acs_ctrl

//--- verif/acs_ctrl_assertions.sv
// port checks for the converter control sequencer
`timescale 1ns/1ps
module acs_ctrl_chk (
   input wire logic sys_clk_in,
   input wire logic nrst_in,
   input wire logic cs_n_in,
   input wire logic dout_oe_out,
   input wire logic [1:0] mux_channel_out,
   input wire logic conv_start_out,
   input wire logic core_power_on_out,
   input wire logic [1:0] power_mode_out,
   input wire logic [1:0] sequence_mode_out,
   input wire logic wake_ready_out
);
   default clocking cb @(posedge sys_clk_in); endclocking
   default disable iff (!nrst_in);
   a_oe_follows_cs: assert property (dout_oe_out == !cs_n_in)
      else $error("oe not tracking select");
   a_start_one_cycle: assert property (conv_start_out |=> !conv_start_out)
      else $error("start pulse too long");
   a_mux_idle_hold: assert property (cs_n_in && $past(cs_n_in) |-> $stable(mux_channel_out))
      else $error("mux moved between frames");
   a_cfg_idle_hold: assert property (cs_n_in && $past(cs_n_in) |->
      $stable({power_mode_out, sequence_mode_out})) else $error("config moved between frames");
   // repeated antecedent absorbs the lag of the power flop after a mode write
   a_full_power_on: assert property ((power_mode_out == 2'h3 && cs_n_in) [*8] |->
      core_power_on_out) else $error("core off in normal mode");
   a_full_power_off: assert property ((power_mode_out == 2'h2 && cs_n_in) [*8] |->
      !core_power_on_out) else $error("core on in full shutdown");
   a_wake_needs_power: assert property (wake_ready_out |-> core_power_on_out)
      else $error("ready while shut down");
   a_wake_delay: assert property ($rose(core_power_on_out) |-> !wake_ready_out [*8])
      else $error("ready too soon after wake");
endmodule // acs_ctrl_chk

//--- verif/acs_host_model.sv
// host serial port model: 16 link clocks a frame, msb first
`timescale 1ns/1ps
module acs_host_model (
   output logic sclk_out,
   output logic cs_n_out,
   output logic din_out,
   input wire logic dout_in
);
   initial
   begin
      sclk_out = 1'h1;
      cs_n_out = 1'h1;
      din_out = 1'h0;
   end
   // one idle fall with select high lets the core take its result
   task automatic frame(input logic [15:0] word, output logic [15:0] rx);
      #32.7 sclk_out = 1'h0;
      #32 sclk_out = 1'h1;
      #32 cs_n_out = 1'h0;
      for (int i = 15; i >= 0; i--)
      begin
         din_out = word[i];
         #32 rx = {rx[14:0], dout_in};
         sclk_out = 1'h0;
         #32 sclk_out = 1'h1;
      end
      #32 cs_n_out = 1'h1;
      din_out = ~din_out; // released line must not show a stale bit
   endtask
endmodule // acs_host_model

//--- verif/acs_ctrl_tb.sv
// self-checking bench for the converter control sequencer
`timescale 1ns/1ps
module acs_ctrl_tb;
   import acs_pkg::*;
   logic sys_clk_in = 1'h0;
   logic nrst_in = 1'h0;
   logic [11:0] result_in = 12'h000;
   wire logic sclk, cs_n, din, dout;
   logic [1:0] mux, pm, sm;
   logic pwr, rng, cod, start, wake;
   int starts = 0;
   int errors = 0;
   int compares = 0;
   logic [11:0] cfg = {1'h0, CFG_RESET};
   logic [15:0] rx;
   // config words: single, no-write, shutdown, auto, continuous, no-write, keep,
   // no-write, exit; power bits never 00 in a write word
   logic [11:0] wd [9] = '{12'hA74, 12'h6EF, 12'hAAE, 12'hAD5, 12'hEBF, 12'h204, 12'hEB4,
      12'h15B, 12'hAF7};
   logic [1:0] mx [9] = '{2'h1, 2'h1, 2'h2, 2'h3, 2'h0, 2'h1, 2'h2, 2'h0, 2'h3};
   always #2 sys_clk_in = ~sys_clk_in;
   // start pulse lasts one cycle; mid-cycle sampling avoids the launch edge
   always @(negedge sys_clk_in)
      if (start === 1'h1)
         starts++;
   acs_ctrl uut (.sys_clk_in(sys_clk_in), .nrst_in(nrst_in), .sclk_in(sclk), .cs_n_in(cs_n),
      .din_in(din), .dout_out(dout), .dout_oe_out(), .result_in(result_in),
      .mux_channel_out(mux), .conv_start_out(start), .core_power_on_out(pwr),
      .range_ref_only_out(rng), .coding_binary_out(cod), .power_mode_out(pm),
      .sequence_mode_out(sm), .wake_ready_out(wake));
   acs_host_model host (.sclk_out(sclk), .cs_n_out(cs_n), .din_out(din), .dout_in(dout));
   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      compares++;
      if (seen !== exp)
      begin
         errors++;
         $display("BAD %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic print_verdict();
      $display("errors %0d compares %0d", errors, compares);
      if (errors == 0 && compares > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask
   task automatic check_cfg();
      chk(pm, cfg[5:4]);
      chk(sm, {cfg[10], cfg[3]});
      chk(rng, cfg[1]);
      chk(cod, cfg[0]);
      if (cfg[5])
         chk(pwr, cfg[4]);
      if (cfg[5:4] == 2'h2)
         chk(wake, 1'h0);
   endtask
   initial
   begin
      #200000 errors++;
      print_verdict();
   end
   initial
   begin
      repeat (20) @(posedge sys_clk_in);
      #1 nrst_in = 1'h1;
      check_cfg();
      for (int i = 0; i < 9; i++)
      begin
         result_in = 12'h5A0 ^ 12'(i);
         host.frame({wd[i], 4'h9}, rx);
         repeat (4) @(posedge sys_clk_in);
         #1 if (wd[i][11]) cfg = wd[i];
         check_cfg();
         chk(mux, mx[i]);
         if (i > 0)
            chk(rx, {2'h0, mx[i-1], result_in});
      end
      chk(16'(starts), 16'h0009);
      chk(wake, 1'h1);
      print_verdict();
   end
endmodule // acs_ctrl_tb
bind acs_ctrl acs_ctrl_chk chk (.sys_clk_in(sys_clk_in), .nrst_in(nrst_in), .cs_n_in(cs_n_in),
   .dout_oe_out(dout_oe_out), .mux_channel_out(mux_channel_out), .conv_start_out(conv_start_out),
   .core_power_on_out(core_power_on_out), .power_mode_out(power_mode_out),
   .sequence_mode_out(sequence_mode_out), .wake_ready_out(wake_ready_out));
